// file: common/ext_decode_pkg.sv
// Package: constants and carriers for the external data paging and I/O decode block
package ext_decode_pkg;
	// ****************************************
	// Register map (APB byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_PAGE = 8'h00;
	localparam logic [7:0] ADDR_IRQ0 = 8'h04;
	localparam logic [7:0] ADDR_NMI = 8'h14;
	localparam logic [7:0] ADDR_IDENT = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_STRAP = 8'h20;
	localparam int NUM_SEL = 5;
	// ****************************************
	// Field layout
	// ****************************************
	localparam int PAGE_W = 5;
	localparam int NVM_SEL_POS = 7;
	localparam int SEL_W = 3;
	localparam int NVM_ADDR_W = 20;
	localparam int LOW_ADDR_W = 15;
	localparam int WIN_BIT = 15;
	// ****************************************
	// I/O region bands, top three address bits
	// ****************************************
	localparam int IO_BAND_LSB = 13;
	localparam logic [2:0] IO_USART = 3'h0;
	localparam logic [2:0] IO_USB = 3'h1;
	localparam logic [2:0] IO_SERIAL = 3'h2;
	localparam logic [2:0] IO_BOARD_MIN = 3'h4;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] SEL_RESET = 8'h00;
	// Board identity value is arbitrary
	localparam logic [7:0] BOARD_IDENT = 8'h5A;
	// ****************************************
	// Strap codes, switches 1..6 in bits 0..5, 1 = ON
	// ****************************************
	localparam logic [5:0] STRAP_FLASH_WE = 6'h0A;
	localparam logic [5:0] STRAP_FLASH_WP = 6'h12;
	localparam logic [5:0] STRAP_EPROM_SMALL = 6'h14;
	localparam logic [5:0] STRAP_EPROM_512K = 6'h24;
	localparam logic [5:0] STRAP_EPROM_1M = 6'h21;
	localparam int ALLOW_SW = 3;
	localparam int BLOCK_SW = 4;

	typedef enum logic [2:0] {
		MEM_NONE,
		MEM_FLASH_WE,
		MEM_FLASH_WP,
		MEM_EPROM_SMALL,
		MEM_EPROM_512K,
		MEM_EPROM_1M
	} mem_type_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic ioSpace;
		logic [15:0] addr;
	} cpu_cycle_t;

	typedef struct packed {
		logic sramSel;
		logic nvmSel;
		logic nvmWrite;
		logic usartSel;
		logic usbSel;
		logic serialSiteSel;
		logic parallelSiteSel;
		logic boardRegSel;
	} sel_t;
endpackage

// file: tb/ext_data_paging_checker.sv
// Checker: decode and paging relations at the block ports
`timescale 1ns/1ps
module ext_data_paging_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire ext_decode_pkg::cpu_cycle_t cpuCycle,
	input wire logic io_region_flag,
	input wire logic [15:0] cpuDataIn,
	input wire logic [15:0] cpuDataOut,
	input wire ext_decode_pkg::sel_t selects,
	input wire logic [19:0] nvmAddr,
	input wire logic [5:0] memory_type_switches
);
	// ****
	// Relations
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic win = cpuCycle.valid && !cpuCycle.ioSpace && cpuCycle.addr[15];
	wire logic io1 = cpuCycle.valid && cpuCycle.ioSpace && io_region_flag;
	wire logic weStrap = memory_type_switches == ext_decode_pkg::STRAP_FLASH_WE;
	a_window_excl: assert property (win |-> selects.sramSel != selects.nvmSel)
		else $error("window select not exclusive");
	a_nvm_addr: assert property (selects.nvmSel |-> win && nvmAddr[14:0] == cpuCycle.addr[14:0])
		else $error("nvm address wrong");
	a_nvm_lane: assert property (selects.nvmSel && !cpuCycle.write |=>
		cpuDataOut == {8'h00, $past(cpuDataIn[7:0])}) else $error("nvm lane wrong");
	a_write_gate: assert property (selects.nvmWrite |-> selects.nvmSel && cpuCycle.write && weStrap)
		else $error("nvm write not allowed");
	a_write_pass: assert property (selects.nvmSel && cpuCycle.write && weStrap |-> selects.nvmWrite)
		else $error("nvm write missing");
	a_io_high: assert property (selects.usartSel || selects.usbSel || selects.serialSiteSel
		|| selects.boardRegSel |-> io1) else $error("io select without flag");
	a_usart_dec: assert property (io1 && cpuCycle.addr[15:13] == 3'h0 |-> selects.usartSel)
		else $error("usart not selected");
	a_par_site: assert property (cpuCycle.valid && cpuCycle.ioSpace |->
		selects.parallelSiteSel == !io_region_flag) else $error("parallel site wrong");
endmodule
bind ext_data_paging ext_data_paging_checker ext_data_paging_checker_inst (.clk, .rst_n,
	.cpuCycle, .io_region_flag, .cpuDataIn, .cpuDataOut, .selects, .nvmAddr,
	.memory_type_switches);

// file: tb/proc_mem_model.sv
// Partner model: data SRAM and byte nonvolatile memory on the processor bus
`timescale 1ns/1ps
module proc_mem_model (
	input wire logic clk,
	input wire ext_decode_pkg::sel_t selects,
	input wire logic [19:0] nvmAddr,
	input wire ext_decode_pkg::cpu_cycle_t cpuCycle,
	output logic [15:0] cpuDataIn
);
	// ****
	// Memory
	// ****
	localparam logic overlayBit = 1'h0;
	logic [15:0] noise = 16'hA5C3;
	always @(posedge clk) noise <= {noise[14:0], noise[15] ^ noise[13]};
	// Byte part leaves the high lane floating, so it churns every cycle
	always_comb begin
		if (selects.nvmSel && !overlayBit) cpuDataIn = {noise[7:0], nvmAddr[7:0] ^ nvmAddr[19:12]};
		else if (selects.sramSel) cpuDataIn = cpuCycle.addr ^ 16'h3C5A;
		else cpuDataIn = ~noise;
	end
endmodule

// file: tb/tb.sv
// Testbench: paging, straps, I/O decode and interrupt routing
`timescale 1ns/1ps
module tb;
	// ****
	// Bench
	// ****
	logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic flag = 1'h0, boot = 1'h0, usart = 1'h0, usb = 1'h0, pready, nmi;
	logic [7:0] paddr = 8'h00, cfg = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] din, dout, ev;
	logic [1:0] oth = 2'h0;
	logic [3:0] irq;
	logic [5:0] sw = 6'h00;
	logic [19:0] na;
	logic [5:0] codes [5] = '{ext_decode_pkg::STRAP_FLASH_WE, ext_decode_pkg::STRAP_FLASH_WP,
		ext_decode_pkg::STRAP_EPROM_SMALL, ext_decode_pkg::STRAP_EPROM_512K,
		ext_decode_pkg::STRAP_EPROM_1M};
	ext_decode_pkg::cpu_cycle_t cyc = '0;
	ext_decode_pkg::sel_t sel, es;
	int err_total = 0, checked = 0, seed = 12, p, a, i, k;
	always #2 clk = ~clk;
	ext_data_paging #(.IRQ_SRC_N(4), .BOARD_REV(8'h02)) ext_data_paging_inst (.clk, .rst_n,
		.clkEn(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr(), .cpuCycle(cyc), .io_region_flag(flag), .cpuDataIn(din),
		.cpuDataOut(dout), .selects(sel), .nvmAddr(na), .byte_nvm_boot_mode(boot),
		.startupConfig(cfg), .memory_type_switches(sw), .usartIrq(usart), .usbIrq(usb),
		.otherIrq(oth), .ext_irq_inputs(irq), .nmiOut(nmi));
	proc_mem_model proc_mem_model_inst (.clk, .selects(sel), .nvmAddr(na), .cpuCycle(cyc),
		.cpuDataIn(din));
	task stop_test;
		if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task cmp(string n, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(logic w, logic [7:0] ad, logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(negedge clk);
		while (!pready) @(negedge clk);
		rd = prdata;
		@(posedge clk);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task cpu(logic io, logic w, logic [15:0] ad);
		@(posedge clk);
		cyc <= '{1'h1, w, io, ad};
		@(posedge clk);
		#1;
	endtask
	task rst(logic m);
		@(posedge clk);
		rst_n <= 1'h0;
		boot <= m;
		cfg <= 8'($random(seed));
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, ext_decode_pkg::ADDR_PAGE, 32'h0);
		cmp("page", {m, 7'h00}, rd[7:0]);
		apb(1'h0, ext_decode_pkg::ADDR_STATUS, 32'h0);
		cmp("status", cfg, rd[7:0]);
	endtask
	initial begin
		#100000;
		err_total++;
		stop_test;
	end
	initial begin
		rst(1'h0);
		apb(1'h0, ext_decode_pkg::ADDR_IDENT, 32'h0);
		cmp("ident", {8'h02, ext_decode_pkg::BOARD_IDENT}, rd[15:0]);
		for (i = 0; i < 6; i++) begin
			p = $random(seed);
			a = $random(seed);
			apb(1'h1, ext_decode_pkg::ADDR_PAGE, {p[31:8], 3'h4, p[4:0]});
			cpu(1'h0, 1'h0, {1'h1, a[14:0]});
			es = '0;
			es.nvmSel = 1'h1;
			cmp("nvmsel", es, sel);
			cmp("nvmaddr", {p[4:0], a[14:0]}, na);
			cmp("lane", {8'h00, din[7:0]}, dout);
		end
		apb(1'h0, ext_decode_pkg::ADDR_PAGE, 32'h0);
		cmp("pageback", {3'h4, p[4:0]}, rd[7:0]);
		apb(1'h1, ext_decode_pkg::ADDR_PAGE, 32'h0);
		cpu(1'h0, 1'h0, 16'hC123);
		es = '0;
		es.sramSel = 1'h1;
		cmp("sramsel", es, sel);
		apb(1'h1, ext_decode_pkg::ADDR_PAGE, 32'h80);
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			sw <= codes[i];
			apb(1'h0, ext_decode_pkg::ADDR_STRAP, 32'h0);
			cmp("strap", {i == 0, 3'(i + 1), codes[i]}, {rd[12], rd[10:8], rd[5:0]});
			cpu(1'h0, 1'h1, 16'h9000);
			cmp("nvmwrite", i == 0, sel.nvmWrite);
		end
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			flag <= i[3];
			cpu(1'h1, 1'h0, {i[2:0], 13'h0ABC});
			es = '0;
			es.parallelSiteSel = !i[3];
			es.boardRegSel = i[3] && i[2];
			es.usartSel = i[3:0] == 8;
			es.usbSel = i[3:0] == 9;
			es.serialSiteSel = i[3:0] == 10;
			cmp("iosel", es, sel);
		end
		for (i = 0; i < 10; i++) begin
			k = $random(seed) & 3;
			apb(1'h1, ext_decode_pkg::ADDR_IRQ0 + 8'(4 * (i % 5)), 32'(k));
			@(posedge clk);
			{oth, usb, usart} <= 4'($random(seed));
			@(posedge clk);
			#1;
			ev = {12'h000, oth, usb, usart};
			cmp("irq", ev[k], i % 5 < 4 ? irq[i % 5] : nmi);
		end
		rst(1'h1);
		stop_test;
	end
endmodule

// file: verilog/ext_data_paging.sv
// Board decode: nonvolatile paging, I/O region decode, interrupt routing, APB registers
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ext_data_paging #(
	parameter int IRQ_SRC_N = 4,
	parameter logic [7:0] BOARD_REV = 8'h02
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor bus
	input wire ext_decode_pkg::cpu_cycle_t cpuCycle,
	input wire logic io_region_flag,
	input wire logic [15:0] cpuDataIn,
	output logic [15:0] cpuDataOut,
	output ext_decode_pkg::sel_t selects,
	output logic [ext_decode_pkg::NVM_ADDR_W-1:0] nvmAddr,
	// Straps and start-up configuration
	input wire logic byte_nvm_boot_mode,
	input wire logic [7:0] startupConfig,
	input wire logic [5:0] memory_type_switches,
	// Interrupts
	input wire logic usartIrq,
	input wire logic usbIrq,
	input wire logic [IRQ_SRC_N-3:0] otherIrq,
	output logic [3:0] ext_irq_inputs,
	output logic nmiOut
);
	initial begin
		if (IRQ_SRC_N < 3 || IRQ_SRC_N > (1 << ext_decode_pkg::SEL_W)) begin
			$error("ext_data_paging: IRQ_SRC_N out of range");
		end
	end

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		RST_HOLD,
		RST_LATCH,
		RUN
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [7:0] page;
		logic [ext_decode_pkg::NUM_SEL-1:0][ext_decode_pkg::SEL_W-1:0] irqSel;
		logic [7:0] startup;
		logic [31:0] rdata;
		logic rdFresh;
		logic [15:0] cpuData;
	} state_t;

	state_t state_reg;
	state_t state_next;

	ext_decode_pkg::mem_type_t memType;
	logic writeAllowed;
	logic [IRQ_SRC_N-1:0] irqSources;
	logic [ext_decode_pkg::NUM_SEL-1:0] irqRouted;
	logic apbWrite;
	logic apbRead;
	logic inWindow;

	function automatic logic [2:0] ioBand(input logic [15:0] a);
		ioBand = a[ext_decode_pkg::IO_BAND_LSB +: 3];
	endfunction

	function automatic logic addrHit(input logic [7:0] a, input logic [7:0] base);
		addrHit = (a == base);
	endfunction

	function automatic logic isSelAddr(input logic [7:0] a, output int idx);
		logic hit;
		hit = 1'b0;
		idx = 0;
		for (int i = 0; i < ext_decode_pkg::NUM_SEL; i++) begin
			if (addrHit(a, 8'(ext_decode_pkg::ADDR_IRQ0 + 8'(4 * i)))) begin
				hit = 1'b1;
				idx = i;
			end
		end
		isSelAddr = hit;
	endfunction

	strap_decode strapDec (
		.memory_type_switches(memory_type_switches),
		.memType(memType),
		.writeAllowed(writeAllowed)
	);

	// ****************************************
	// Interrupt routing
	// ****************************************
	assign irqSources = {otherIrq, usbIrq, usartIrq};

	genvar g;
	generate
		for (g = 0; g < ext_decode_pkg::NUM_SEL; g++) begin : gRoute
			irq_route #(
				.SRC_N(IRQ_SRC_N)
			) route (
				.sources(irqSources),
				.select(state_reg.irqSel[g]),
				.irqOut(irqRouted[g])
			);
		end
	endgenerate

	assign ext_irq_inputs = irqRouted[3:0];
	assign nmiOut = irqRouted[4];

	// ****************************************
	// Processor bus decode
	// ****************************************
	assign inWindow = cpuCycle.addr[ext_decode_pkg::WIN_BIT];

	always_comb begin
		selects = '0;
		if (cpuCycle.valid && !cpuCycle.ioSpace && inWindow) begin
			// Window served without qualification; overlay bit is the processor's job
			if (state_reg.page[ext_decode_pkg::NVM_SEL_POS]) begin
				selects.nvmSel = 1'b1;
				selects.nvmWrite = cpuCycle.write && writeAllowed;
			end else begin
				selects.sramSel = 1'b1;
			end
		end
		if (cpuCycle.valid && cpuCycle.ioSpace) begin
			// Flag is sampled per cycle; software covers the pipeline lag
			if (io_region_flag) begin
				case (ioBand(cpuCycle.addr))
					ext_decode_pkg::IO_USART: begin
						selects.usartSel = 1'b1;
					end
					ext_decode_pkg::IO_USB: begin
						selects.usbSel = 1'b1;
					end
					ext_decode_pkg::IO_SERIAL: begin
						selects.serialSiteSel = 1'b1;
					end
					default: begin
						// The band between serial site and registers stays unclaimed
						selects.boardRegSel = ioBand(cpuCycle.addr) >= ext_decode_pkg::IO_BOARD_MIN;
					end
				endcase
			end else begin
				selects.parallelSiteSel = 1'b1;
			end
		end
	end

	assign nvmAddr = {state_reg.page[ext_decode_pkg::PAGE_W-1:0],
		cpuCycle.addr[ext_decode_pkg::LOW_ADDR_W-1:0]};
	assign cpuDataOut = state_reg.cpuData;

	// ****************************************
	// APB access
	// ****************************************
	assign apbWrite = psel && penable && pwrite && clkEn && (state_reg.phase == RUN);
	// Read data is caught only in RUN; a setup that fell in RST_LATCH gets one extra wait
	// cycle, so the latched straps are what the first read returns
	assign apbRead = psel && !pwrite && (state_reg.phase == RUN)
		&& !(penable && state_reg.rdFresh);
	assign pready = clkEn && (state_reg.phase == RUN)
		&& (pwrite || !penable || state_reg.rdFresh);
	assign pslverr = 1'b0;
	assign prdata = state_reg.rdata;

	always_comb begin
		int idx;
		idx = 0;
		state_next = state_reg;
		case (state_reg.phase)
			RST_HOLD: begin
				state_next.phase = RST_LATCH;
			end
			RST_LATCH: begin
				// Straps caught after reset release, never in the reset branch
				state_next.startup = startupConfig;
				state_next.page[ext_decode_pkg::NVM_SEL_POS] = byte_nvm_boot_mode;
				state_next.phase = RUN;
			end
			RUN: begin
				if (apbWrite) begin
					if (addrHit(paddr, ext_decode_pkg::ADDR_PAGE)) begin
						state_next.page = pwdata[7:0];
					end else if (isSelAddr(paddr, idx)) begin
						state_next.irqSel[idx] = pwdata[ext_decode_pkg::SEL_W-1:0];
					end
				end
			end
			default: begin
				state_next.phase = RST_HOLD;
			end
		endcase
		// Read data captured in setup so it is stable through the access phase
		if (apbRead) begin
			state_next.rdFresh = 1'b1;
			state_next.rdata = '0;
			if (addrHit(paddr, ext_decode_pkg::ADDR_PAGE)) begin
				state_next.rdata[7:0] = state_reg.page;
			end else if (isSelAddr(paddr, idx)) begin
				state_next.rdata[ext_decode_pkg::SEL_W-1:0] = state_reg.irqSel[idx];
			end else if (addrHit(paddr, ext_decode_pkg::ADDR_IDENT)) begin
				state_next.rdata[15:0] = {BOARD_REV, ext_decode_pkg::BOARD_IDENT};
			end else if (addrHit(paddr, ext_decode_pkg::ADDR_STATUS)) begin
				state_next.rdata[7:0] = state_reg.startup;
			end else if (addrHit(paddr, ext_decode_pkg::ADDR_STRAP)) begin
				state_next.rdata[5:0] = memory_type_switches;
				state_next.rdata[10:8] = memType;
				state_next.rdata[12] = writeAllowed;
			end
		end else if (psel && penable && pready) begin
			state_next.rdFresh = 1'b0;
		end
		// Nonvolatile data on low lane only, high lane driven zero
		if (selects.nvmSel && !cpuCycle.write) begin
			state_next.cpuData = {8'h00, cpuDataIn[7:0]};
		end else if (selects.sramSel && !cpuCycle.write) begin
			state_next.cpuData = cpuDataIn;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.phase <= RST_HOLD;
			state_reg.page <= ext_decode_pkg::PAGE_RESET;
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end
endmodule

// file: verilog/irq_route.sv
// Interrupt source multiplexer for one processor input
`timescale 1ns/1ps
module irq_route #(
	parameter int SRC_N = 4
) (
	input wire logic [SRC_N-1:0] sources,
	input wire logic [ext_decode_pkg::SEL_W-1:0] select,
	output logic irqOut
);
	initial begin
		if (SRC_N < 1 || SRC_N > (1 << ext_decode_pkg::SEL_W)) begin
			$error("irq_route: SRC_N out of range");
		end
	end

	// Codes past the last source give a quiet line
	always_comb begin
		irqOut = 1'b0;
		for (int i = 0; i < SRC_N; i++) begin
			if (select == i[ext_decode_pkg::SEL_W-1:0]) begin
				irqOut = sources[i];
			end
		end
	end
endmodule

// file: verilog/strap_decode.sv
// Memory type strap decoder
`timescale 1ns/1ps
module strap_decode (
	input wire logic [5:0] memory_type_switches,
	output ext_decode_pkg::mem_type_t memType,
	output logic writeAllowed
);
	always_comb begin
		case (memory_type_switches)
			ext_decode_pkg::STRAP_FLASH_WE: memType = ext_decode_pkg::MEM_FLASH_WE;
			ext_decode_pkg::STRAP_FLASH_WP: memType = ext_decode_pkg::MEM_FLASH_WP;
			ext_decode_pkg::STRAP_EPROM_SMALL: memType = ext_decode_pkg::MEM_EPROM_SMALL;
			ext_decode_pkg::STRAP_EPROM_512K: memType = ext_decode_pkg::MEM_EPROM_512K;
			ext_decode_pkg::STRAP_EPROM_1M: memType = ext_decode_pkg::MEM_EPROM_1M;
			default: memType = ext_decode_pkg::MEM_NONE;
		endcase
	end

	// Only a flash with allow on and block off may be written
	assign writeAllowed = (memType == ext_decode_pkg::MEM_FLASH_WE)
		&& memory_type_switches[ext_decode_pkg::ALLOW_SW]
		&& !memory_type_switches[ext_decode_pkg::BLOCK_SW];
endmodule
